// >>> src/decoupled_fetch_execute_pipeline.sv
`timescale 1ns/10ps
`default_nettype none

module decoupled_fetch_execute_pipeline
    import pipe_pkg::*;
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire logic                clkEn,
    // Bus clock ratio strap and bus clock enable
    input  wire logic [1:0]          busRatioSel,
    output logic                     busClkEn,
    // Instruction fetch port of the local bus
    output logic                     fetchReq,
    output logic      [ADDR_W-1:0]   fetchAddr,
    input  wire logic                fetchRdValid,
    input  wire logic [DATA_W-1:0]   fetchRdData,
    // Operand port of the local bus
    output logic                     opReq,
    output logic                     opWe,
    output logic      [ADDR_W-1:0]   opAddr,
    output logic      [DATA_W-1:0]   opWrData,
    input  wire logic                opRdValid,
    input  wire logic [DATA_W-1:0]   opRdData,
    // Retirement
    output logic                     retireValid,
    output logic      [DATA_W-1:0]   retireResult,
    output logic                     retireTwoPass
);
    localparam int IW  = $bits(instr_t);
    localparam int WLW = $clog2(WORDBUF_DEPTH + 1);

    typedef struct packed {
        logic [1:0]        ratioMeta;
        logic [1:0]        ratioSync;
        logic [1:0]        ratioAge;
        logic              ratioCaught;
        logic [2:0]        ratioDiv;
        logic [2:0]        busDiv;
        logic              busClkEn;
        logic [ADDR_W-1:0] pfAddr;
        logic              aVld;
        logic [ADDR_W-1:0] aAddr;
        logic              bVld;
        logic              parcelLo;
        logic [1:0]        asmCnt;
        instr_t            asm;
        logic              dVld;
        pass_t             dPass;
        instr_t            dInstr;
        logic [DATA_W-1:0] dOperand;
        logic              xVld;
        instr_class_t      xCls;
        alu_op_t           xOp;
        logic [REG_AW-1:0] xRd;
        logic              xHasExt;
        logic              xPass2;
        logic [DATA_W-1:0] xA;
        logic [DATA_W-1:0] xB;
        logic [DATA_W-1:0] xExt;
        logic [ADDR_W-1:0] memAddr;
        logic              opReq;
        logic              opWe;
        logic [ADDR_W-1:0] opAddr;
        logic [DATA_W-1:0] opWrData;
        logic              rtVld;
        logic [DATA_W-1:0] rtRes;
        logic              rtTwo;
    } pipe_state_t;

    pipe_state_t q_reg;
    pipe_state_t q_next;

    stream_if #(.W(DATA_W)) wordIn ();
    stream_if #(.W(DATA_W)) wordOut ();
    stream_if #(.W(IW))     queueIn ();
    stream_if #(.W(IW))     queueOut ();

    logic [WLW-1:0]      wordLevel;
    logic [REG_AW-1:0]   rdIdx;
    logic [REG_AW-1:0]   rsIdx;
    logic [DATA_W-1:0]   rfA;
    logic [DATA_W-1:0]   rfB;
    logic                wrEn;
    logic [DATA_W-1:0]   wrData;
    logic                bDone;
    logic                aMove;
    logic                issue;
    logic [2:0]          wordsOwed;
    logic [PARCEL_W-1:0] parcel;
    logic                asmFull;
    logic                asmLeave;
    logic                take;
    logic                bypass;
    logic                dFree;
    logic                dToX;
    instr_class_t        dCls;
    logic                memRead;
    logic [DATA_W-1:0]   rdVal;
    logic [DATA_W-1:0]   rsVal;
    logic [DATA_W-1:0]   ext;
    logic [DATA_W-1:0]   bEff;
    logic [DATA_W-1:0]   res;
    logic [ADDR_W-1:0]   memA;

    function automatic logic [1:0] lenOf(input logic [PARCEL_W-1:0] p);
        case (p[LEN_HI:LEN_LO])
            LEN_CODE_ONE: lenOf = LEN_ONE;
            LEN_CODE_TWO: lenOf = LEN_TWO;
            default:      lenOf = LEN_THREE;
        endcase
    endfunction : lenOf

    function automatic logic [DATA_W-1:0] aluCalc(input alu_op_t op,
                                                  input logic [DATA_W-1:0] a,
                                                  input logic [DATA_W-1:0] b);
        case (op)
            ALU_ADD: aluCalc = a + b;
            ALU_SUB: aluCalc = a - b;
            ALU_AND: aluCalc = a & b;
            ALU_OR:  aluCalc = a | b;
            default: aluCalc = a;
        endcase
    endfunction : aluCalc

    // Prefetched words wait here so a decode stall loses no bus answer
    stream_fifo #(.W(DATA_W), .DEPTH(WORDBUF_DEPTH)) wordBuf (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .inPort  (wordIn),
        .outPort (wordOut),
        .level   (wordLevel)
    );

    stream_fifo #(.W(IW), .DEPTH(QUEUE_DEPTH)) instrQueue (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .inPort  (queueIn),
        .outPort (queueOut),
        .level   ()
    );

    dual_read_regfile regFile (
        .clk     (clk),
        .sys_rst (sys_rst),
        .clkEn   (clkEn),
        .rdAddrA (rdIdx),
        .rdAddrB (rsIdx),
        .rdDataA (rfA),
        .rdDataB (rfB),
        .wrEn    (wrEn),
        .wrAddr  (q_reg.xRd),
        .wrData  (wrData)
    );

    assign busClkEn      = q_reg.busClkEn;
    assign fetchReq      = q_reg.aVld;
    assign fetchAddr     = q_reg.aAddr;
    assign opReq         = q_reg.opReq;
    assign opWe          = q_reg.opWe;
    assign opAddr        = q_reg.opAddr;
    assign opWrData      = q_reg.opWrData;
    assign retireValid   = q_reg.rtVld;
    assign retireResult  = q_reg.rtRes;
    assign retireTwoPass = q_reg.rtTwo;

    assign wordIn.valid  = bDone;
    assign wordIn.data   = fetchRdData;
    assign rdIdx         = q_reg.dInstr.words[2][RD_HI:RD_LO];
    assign rsIdx         = q_reg.dInstr.words[2][RS_HI:RS_LO];

    always_comb
    begin
        q_next = q_reg;

        // Strap passes two flops and is caught once it has settled
        q_next.ratioMeta = busRatioSel;
        q_next.ratioSync = q_reg.ratioMeta;
        if (!q_reg.ratioCaught)
        begin
            q_next.ratioAge = q_reg.ratioAge + 2'h1;
            if (q_reg.ratioAge == RATIO_SETTLE)
            begin
                q_next.ratioCaught = 1'b1;
                case (q_reg.ratioSync)
                    RATIO_HALF:  q_next.ratioDiv = DIV_HALF;
                    RATIO_THIRD: q_next.ratioDiv = DIV_THIRD;
                    default:     q_next.ratioDiv = DIV_QUARTER;
                endcase
            end
        end
        q_next.busClkEn = 1'b0;
        if (q_reg.ratioCaught)
        begin
            if (q_reg.busDiv >= q_reg.ratioDiv - 3'h1)
            begin
                q_next.busDiv   = 3'h0;
                q_next.busClkEn = 1'b1;
            end
            else
                q_next.busDiv = q_reg.busDiv + 3'h1;
        end

        // Fetch: address, launch, completion; one access in flight per stage
        bDone = q_reg.bVld && fetchRdValid;
        aMove = q_reg.aVld && (!q_reg.bVld || bDone);
        // Words owed to the buffer once this cycle ends, before any new launch
        wordsOwed = 3'(wordLevel) + 3'(q_reg.aVld) + 3'(q_reg.bVld)
                  - 3'(wordOut.valid && wordOut.ready);
        issue = (!q_reg.aVld || aMove) && wordIn.ready
              && (wordsOwed < 3'(WORDBUF_DEPTH));
        q_next.pfAddr = issue ? q_reg.pfAddr + ADDR_STEP : q_reg.pfAddr;
        if (issue)
        begin
            q_next.aVld  = 1'b1;
            q_next.aAddr = q_reg.pfAddr;
        end
        else if (aMove)
            q_next.aVld = 1'b0;
        if (aMove)
            q_next.bVld = 1'b1;
        else if (bDone)
            q_next.bVld = 1'b0;

        // Execution first stage: decode, register read, operand capture
        dCls    = instr_class_t'(q_reg.dInstr.words[2][CLS_HI:CLS_LO]);
        memRead = (dCls == CLS_LOAD) || (dCls == CLS_RMW);
        wrEn    = q_reg.xVld && ((q_reg.xCls == CLS_REG)
                  || (q_reg.xCls == CLS_LOAD && q_reg.xPass2));
        bEff    = (q_reg.xCls == CLS_REG && q_reg.xHasExt) ? q_reg.xExt
                                                            : q_reg.xB;
        res     = aluCalc(q_reg.xOp, q_reg.xA, bEff);
        memA    = q_reg.xB + q_reg.xExt;
        wrData  = (q_reg.xCls == CLS_LOAD) ? q_reg.xB : res;
        // Forward the result leaving the second stage this cycle
        rdVal   = (wrEn && q_reg.xRd == rdIdx) ? wrData : rfA;
        rsVal   = (wrEn && q_reg.xRd == rsIdx) ? wrData : rfB;
        if (q_reg.dInstr.len == LEN_THREE)
            ext = {q_reg.dInstr.words[1], q_reg.dInstr.words[0]};
        else
            ext = {{PARCEL_W{q_reg.dInstr.words[1][PARCEL_W-1]}},
                   q_reg.dInstr.words[1]};
        dToX  = 1'b0;
        dFree = !q_reg.dVld;
        if (q_reg.dVld)
        begin
            case (q_reg.dPass)
                PASS_ONE:
                begin
                    dToX = 1'b1;
                    if (memRead)
                        q_next.dPass = PASS_WAIT;
                    else
                        dFree = 1'b1;
                end
                PASS_WAIT:
                begin
                    if (opRdValid)
                    begin
                        q_next.dOperand = opRdData;
                        q_next.dPass    = PASS_TWO;
                    end
                end
                PASS_TWO:
                begin
                    dToX         = 1'b1;
                    dFree        = 1'b1;
                    q_next.dPass = PASS_ONE;
                end
                default: q_next.dPass = PASS_ONE;
            endcase
        end
        q_next.xVld = dToX;
        if (dToX)
        begin
            q_next.xCls    = dCls;
            q_next.xOp     = alu_op_t'(q_reg.dInstr.words[2][OP_HI:OP_LO]);
            q_next.xRd     = rdIdx;
            q_next.xHasExt = (q_reg.dInstr.len != LEN_ONE);
            q_next.xPass2  = (q_reg.dPass == PASS_TWO);
            q_next.xA      = rdVal;
            q_next.xB      = (q_reg.dPass == PASS_TWO) ? q_reg.dOperand
                                                      : rsVal;
            q_next.xExt    = ext;
        end

        // Early decode: one parcel a cycle, high half of each word first
        parcel   = q_reg.parcelLo ? wordOut.data[PARCEL_W-1:0]
                                  : wordOut.data[DATA_W-1:PARCEL_W];
        asmFull  = (q_reg.asmCnt != 2'h0) && (q_reg.asmCnt == q_reg.asm.len);
        bypass   = asmFull && dFree && !queueOut.valid;
        asmLeave = asmFull && (bypass || queueIn.ready);
        take     = wordOut.valid && (!asmFull || asmLeave);
        wordOut.ready = take && q_reg.parcelLo;
        queueIn.valid = asmFull && !bypass;
        queueIn.data  = q_reg.asm;
        if (asmLeave)
            q_next.asmCnt = 2'h0;
        if (take)
        begin
            q_next.parcelLo = !q_reg.parcelLo;
            if (q_reg.asmCnt == 2'h0 || asmLeave)
            begin
                q_next.asm.len      = lenOf(parcel);
                q_next.asm.words[2] = parcel;
                q_next.asmCnt       = 2'h1;
            end
            else
            begin
                q_next.asm.words[2'h2 - q_reg.asmCnt] = parcel;
                q_next.asmCnt = q_reg.asmCnt + 2'h1;
            end
        end

        // Execution never waits on an empty queue while an instruction is assembled; order is kept by the bypass
        queueOut.ready = dFree;
        if (dFree)
        begin
            if (queueOut.valid)
            begin
                q_next.dVld   = 1'b1;
                q_next.dInstr = queueOut.data;
            end
            else if (bypass)
            begin
                q_next.dVld   = 1'b1;
                q_next.dInstr = q_reg.asm;
            end
            else
                q_next.dVld = 1'b0;
        end

        // Execution second stage: operand address or the operation itself
        q_next.opReq = 1'b0;
        q_next.opWe  = 1'b0;
        q_next.rtVld = 1'b0;
        q_next.rtTwo = q_reg.xPass2;
        if (q_reg.xVld)
        begin
            case (q_reg.xCls)
                CLS_STORE:
                begin
                    q_next.opReq    = 1'b1;
                    q_next.opWe     = 1'b1;
                    q_next.opAddr   = memA;
                    q_next.opWrData = q_reg.xA;
                    q_next.rtVld    = 1'b1;
                    q_next.rtRes    = q_reg.xA;
                end
                CLS_LOAD,
                CLS_RMW:
                begin
                    if (!q_reg.xPass2)
                    begin
                        q_next.opReq   = 1'b1;
                        q_next.opAddr  = memA;
                        q_next.memAddr = memA;
                    end
                    else
                    begin
                        q_next.rtVld = 1'b1;
                        q_next.rtRes = wrData;
                        if (q_reg.xCls == CLS_RMW)
                        begin
                            q_next.opReq    = 1'b1;
                            q_next.opWe     = 1'b1;
                            q_next.opAddr   = q_reg.memAddr;
                            q_next.opWrData = res;
                        end
                    end
                end
                default:
                begin
                    q_next.rtVld = 1'b1;
                    q_next.rtRes = res;
                end
            endcase
        end
    end

    // Clock is the doubled core clock shared with cache and SRAM
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            q_reg        <= '0;
            q_reg.pfAddr <= PC_RESET;
        end
        else if (clkEn)
            q_reg <= q_next;
    end

endmodule : decoupled_fetch_execute_pipeline

`default_nettype wire

// >>> shared/pipe_pkg.sv
package pipe_pkg;

    // Widths and depths
    localparam int ADDR_W        = 32;
    localparam int DATA_W        = 32;
    localparam int PARCEL_W      = 16;
    localparam int REG_COUNT     = 16;
    localparam int REG_AW        = 4;
    localparam int QUEUE_DEPTH   = 8;
    localparam int WORDBUF_DEPTH = 2;

    // Prefetch address
    localparam logic [31:0] PC_RESET  = 32'h0000_0000;
    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

    // First parcel of an instruction
    localparam int LEN_HI = 15;
    localparam int LEN_LO = 14;
    localparam int CLS_HI = 13;
    localparam int CLS_LO = 12;
    localparam int RD_HI  = 11;
    localparam int RD_LO  = 8;
    localparam int RS_HI  = 7;
    localparam int RS_LO  = 4;
    localparam int OP_HI  = 1;
    localparam int OP_LO  = 0;

    // Length code to parcel count
    localparam logic [1:0] LEN_CODE_ONE = 2'h0;
    localparam logic [1:0] LEN_CODE_TWO = 2'h1;
    localparam logic [1:0] LEN_ONE      = 2'h1;
    localparam logic [1:0] LEN_TWO      = 2'h2;
    localparam logic [1:0] LEN_THREE    = 2'h3;

    // Bus clock ratio strap and divisors
    localparam logic [1:0] RATIO_HALF   = 2'h0;
    localparam logic [1:0] RATIO_THIRD  = 2'h1;
    localparam logic [2:0] DIV_HALF     = 3'h2;
    localparam logic [2:0] DIV_THIRD    = 3'h3;
    localparam logic [2:0] DIV_QUARTER  = 3'h4;
    localparam logic [1:0] RATIO_SETTLE = 2'h2;

    // Processor clock
    localparam int CLK_PERIOD_NS = 25;

    typedef enum logic [1:0] {
        CLS_REG   = 2'h0,
        CLS_STORE = 2'h1,
        CLS_LOAD  = 2'h2,
        CLS_RMW   = 2'h3
    } instr_class_t;

    typedef enum logic [1:0] {
        ALU_ADD = 2'h0,
        ALU_SUB = 2'h1,
        ALU_AND = 2'h2,
        ALU_OR  = 2'h3
    } alu_op_t;

    // Gray along ONE -> WAIT -> TWO
    typedef enum logic [1:0] {
        PASS_ONE  = 2'h0,
        PASS_WAIT = 2'h1,
        PASS_TWO  = 2'h3
    } pass_t;

    typedef struct packed {
        logic [1:0]               len;
        logic [2:0][PARCEL_W-1:0] words;
    } instr_t;

endpackage : pipe_pkg

// >>> shared/stream_if.sv
`timescale 1ns/10ps
`default_nettype none

interface stream_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : stream_if

`default_nettype wire

// >>> src/stream_fifo.sv
`timescale 1ns/10ps
`default_nettype none

module stream_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 2,
    parameter int LW    = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          sys_rst,
    input  wire logic          clkEn,
    // Streams
    stream_if.snk              inPort,
    stream_if.src              outPort,
    // Occupancy
    output logic [LW-1:0]      level
);
    // Shift style: head is always slot 0, so the output comes from a flop
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] data;
        logic [DEPTH-1:0]        vld;
    } fifo_state_t;

    fifo_state_t q_reg;
    fifo_state_t q_next;
    logic        pop;
    logic        placed;

    assign outPort.valid = q_reg.vld[0];
    assign outPort.data  = q_reg.data[0];
    // Ready from a flop: a full buffer refuses even when popping
    assign inPort.ready  = !q_reg.vld[DEPTH-1];

    always_comb
    begin
        q_next = q_reg;
        placed = 1'b0;
        level  = '0;
        pop    = q_reg.vld[0] && outPort.ready;
        if (pop)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
            begin
                q_next.data[i] = q_reg.data[i+1];
                q_next.vld[i]  = q_reg.vld[i+1];
            end
            q_next.vld[DEPTH-1] = 1'b0;
        end
        if (inPort.valid && !q_reg.vld[DEPTH-1])
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                if (!placed && !q_next.vld[i])
                begin
                    q_next.data[i] = inPort.data;
                    q_next.vld[i]  = 1'b1;
                    placed         = 1'b1;
                end
            end
        end
        for (int i = 0; i < DEPTH; i++)
        begin
            level = level + LW'(q_reg.vld[i]);
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            q_reg <= '0;
        else if (clkEn)
            q_reg <= q_next;
    end

endmodule : stream_fifo

`default_nettype wire

// >>> src/dual_read_regfile.sv
`timescale 1ns/10ps
`default_nettype none

module dual_read_regfile
    import pipe_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              clkEn,
    // Read ports
    input  wire logic [REG_AW-1:0] rdAddrA,
    input  wire logic [REG_AW-1:0] rdAddrB,
    output logic      [DATA_W-1:0] rdDataA,
    output logic      [DATA_W-1:0] rdDataB,
    // Write port
    input  wire logic              wrEn,
    input  wire logic [REG_AW-1:0] wrAddr,
    input  wire logic [DATA_W-1:0] wrData
);
    typedef struct packed {
        logic [REG_COUNT-1:0][DATA_W-1:0] regs;
    } rf_state_t;

    rf_state_t q_reg;
    rf_state_t q_next;

    assign rdDataA = q_reg.regs[rdAddrA];
    assign rdDataB = q_reg.regs[rdAddrB];

    always_comb
    begin
        q_next = q_reg;
        if (wrEn)
            q_next.regs[wrAddr] = wrData;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            q_reg <= '0;
        else if (clkEn)
            q_reg <= q_next;
    end

endmodule : dual_read_regfile

`default_nettype wire

// >>> bench/pipe_monitor.sv
`timescale 1ns/10ps
`default_nettype none

module pipe_monitor
    import pipe_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Bus ratio
    input  wire logic [1:0]        busRatioSel,
    input  wire logic              busClkEn,
    // Local bus
    input  wire logic              fetchReq,
    input  wire logic [ADDR_W-1:0] fetchAddr,
    input  wire logic              opReq,
    input  wire logic              opWe,
    input  wire logic [DATA_W-1:0] opWrData,
    input  wire logic              opRdValid,
    input  wire logic [DATA_W-1:0] opRdData,
    // Retirement
    input  wire logic              retireValid,
    input  wire logic [DATA_W-1:0] retireResult,
    input  wire logic              retireTwoPass
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_busone;
        busClkEn |=> !busClkEn;
    endproperty
    a_busone: assert property (p_busone) else $error("bus pulse long");
    property p_bushalf;
        busClkEn && busRatioSel == RATIO_HALF |=> !busClkEn ##1 busClkEn;
    endproperty
    a_bushalf: assert property (p_bushalf) else $error("half gap");
    property p_busquarter;
        busClkEn && busRatioSel[1] |=> !busClkEn [*3] ##1 busClkEn;
    endproperty
    a_busquarter: assert property (p_busquarter) else $error("quarter");
    property p_addrstep;
        fetchReq && $past(fetchReq) && fetchAddr != $past(fetchAddr)
            |-> fetchAddr == $past(fetchAddr) + ADDR_STEP;
    endproperty
    a_addrstep: assert property (p_addrstep) else $error("fetch step");
    property p_store;
        opReq && opWe |-> retireValid && retireResult == opWrData;
    endproperty
    a_store: assert property (p_store) else $error("store retire");
    property p_twopass;
        retireValid && retireTwoPass |-> $past(opRdValid, 3);
    endproperty
    a_twopass: assert property (p_twopass) else $error("two pass");
    property p_readret;
        opRdValid |-> ##3 (retireValid && retireTwoPass);
    endproperty
    a_readret: assert property (p_readret) else $error("second pass");
    property p_loadval;
        retireValid && retireTwoPass && !$past(opReq)
            |-> retireResult == $past(opRdData, 3);
    endproperty
    a_loadval: assert property (p_loadval) else $error("load value");
endmodule : pipe_monitor

`default_nettype wire

// >>> bench/mem_model.sv
`timescale 1ns/10ps
`default_nettype none

module mem_model
(
    // Clock, reset and wait states
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  fWait,
    input  wire logic [7:0]  oWait,
    // Fetch side
    input  wire logic        fetchReq,
    input  wire logic [31:0] fetchAddr,
    output logic             fetchRdValid,
    output logic [31:0]      fetchRdData,
    // Operand side
    input  wire logic        opReq,
    input  wire logic        opWe,
    input  wire logic [31:0] opAddr,
    output logic             opRdValid,
    output logic [31:0]      opRdData
);
    localparam logic [31:0] IMG [6] = '{32'h4100_0005, 32'h8220_0001,
        32'h0000_0313, 32'h5100_0040, 32'h6400_0080, 32'h7003_00c0};
    logic [31:0] fA, oA;
    logic [7:0]  fN, oN;
    logic        fPend, oPend, fTake, oTake, fDue, oDue;

    function automatic logic [31:0] img(input logic [31:0] a);
        return (a < 32'h18) ? IMG[a[4:2]] : 32'h0;
    endfunction : img

    assign fTake = fetchReq && (!fPend || fetchRdValid);
    assign fDue  = fTake ? fWait == 8'h0 : fPend && !fetchRdValid && fN == 8'h1;
    assign oTake = opReq && !opWe;
    assign oDue  = oTake ? oWait == 8'h0 : oPend && !opRdValid && oN == 8'h1;

    // Released data lines flip to the inverse of their current value every cycle
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fPend <= 1'b0;
            oPend <= 1'b0;
            fetchRdValid <= 1'b0;
            opRdValid <= 1'b0;
            fetchRdData <= 32'h0;
            opRdData <= 32'h0;
        end
        else
        begin
            fPend <= fTake || (fPend && !fetchRdValid);
            fA <= fTake ? fetchAddr : fA;
            fN <= fTake ? fWait : fN - 8'h1;
            fetchRdValid <= fDue;
            fetchRdData <= fDue ? img(fTake ? fetchAddr : fA) : ~fetchRdData;
            oPend <= oTake || (oPend && !opRdValid);
            oA <= oTake ? opAddr : oA;
            oN <= oTake ? oWait : oN - 8'h1;
            opRdValid <= oDue;
            opRdData <= oDue ? (oTake ? opAddr : oA) ^ 32'h5a5a_0000 : ~opRdData;
        end
    end
endmodule : mem_model

`default_nettype wire

// >>> bench/decoupled_fetch_execute_pipeline_test.sv
`timescale 1ns/10ps
`default_nettype none

module decoupled_fetch_execute_pipeline_test;
    logic        clk = 1'b0, sys_rst = 1'b1;
    logic [1:0]  busRatioSel = 2'h0;
    logic [7:0]  fWait = 8'h0, oWait = 8'h0;
    logic        busClkEn, fetchReq, fetchRdValid, opReq, opWe, opRdValid;
    logic        retireValid, retireTwoPass;
    logic [31:0] fetchAddr, fetchRdData, opAddr, opWrData, opRdData;
    logic [31:0] retireResult;
    int          failures = 0, n_tests = 0;

    always #12.5 clk = ~clk;

    decoupled_fetch_execute_pipeline u_dut(.clk, .sys_rst, .clkEn(1'b1),
        .busRatioSel, .busClkEn, .fetchReq, .fetchAddr, .fetchRdValid,
        .fetchRdData, .opReq, .opWe, .opAddr, .opWrData, .opRdValid,
        .opRdData, .retireValid, .retireResult, .retireTwoPass);
    mem_model u_mem(.clk, .sys_rst, .fWait, .oWait, .fetchReq, .fetchAddr,
        .fetchRdValid, .fetchRdData, .opReq, .opWe, .opAddr, .opRdValid,
        .opRdData);

    task automatic tick;
        @(posedge clk);
        #2;
    endtask : tick

    task automatic check(input string what, input logic [31:0] exp, got);
        n_tests++;
        if (got !== exp)
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        if (got !== exp)
            failures++;
    endtask : check

    task automatic restart(input logic [1:0] s);
        sys_rst = 1'b1;
        busRatioSel = s;
        repeat (6) tick;
        sys_rst = 1'b0;
    endtask : restart

    task automatic bus_ratio;
        int gap;
        for (int s = 0; s < 4; s++)
        begin
            restart(s[1:0]);
            for (int c = 0; c < 20 && busClkEn !== 1'b1; c++)
                tick;
            gap = 0;
            do
            begin
                tick;
                gap++;
            end while (busClkEn !== 1'b1 && gap < 10);
            check("bus gap", s < 2 ? s + 2 : 4, gap);
        end
    endtask : bus_ratio

    task automatic run_prog(input logic [7:0] fw, ow);
        logic [31:0] res [6] = '{32'h5, 32'h10000, 32'h5, 32'h5,
            32'h5a5a0080, 32'h5a5a00c0};
        int k = 0;
        fWait = fw;
        oWait = ow;
        restart(2'h0);
        tick;
        check("fetchReq", 1, fetchReq);
        check("fetchAddr", 0, fetchAddr);
        for (int c = 0; c < 600 && k < 6; c++)
        begin
            if (opReq === 1'b1)
                check("opAddr", (k == 3) ? 32'h40
                    : (k == 4) ? 32'h80 : 32'hc0, opAddr);
            if (ow > 20 && opRdValid === 1'b1)
                check("fetch stall", 0, fetchReq);
            if (retireValid === 1'b1)
            begin
                check("retireResult", res[k], retireResult);
                check("retireTwoPass", k > 3, retireTwoPass);
                k++;
            end
            tick;
        end
        check("retired", 6, k);
    endtask : run_prog

    // Trailing one-parcel adds should stream at close to one per cycle
    task automatic throughput;
        int n = 0;
        repeat (40)
        begin
            tick;
            n += (retireValid === 1'b1);
        end
        check("retire rate", 1, n >= 30);
    endtask : throughput

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        bus_ratio;
        run_prog(8'h0, 8'h0);
        throughput;
        run_prog(8'h3, 8'h60);
        tally_and_finish;
    end

    initial
    begin
        #(25 * 5000);
        failures++;
        tally_and_finish;
    end
endmodule : decoupled_fetch_execute_pipeline_test

bind decoupled_fetch_execute_pipeline pipe_monitor u_mon(.clk, .sys_rst,
    .busRatioSel, .busClkEn, .fetchReq, .fetchAddr, .opReq, .opWe,
    .opWrData, .opRdValid, .opRdData, .retireValid, .retireResult,
    .retireTwoPass);

`default_nettype wire
